// ### logic/rssx_pkg.sv
// Package: register map, field positions, op codes and state types for the skip/subtract datapath
package rssx_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [3:0] RSSX_OFS_CTRL = 4'h0;
    localparam logic [3:0] RSSX_OFS_ACC = 4'h1;
    localparam logic [3:0] RSSX_OFS_FLAGS = 4'h2;
    localparam logic [3:0] RSSX_OFS_MEM = 4'h3;
    localparam logic [3:0] RSSX_OFS_IMM = 4'h4;
    localparam logic [3:0] RSSX_OFS_STATUS = 4'h5;
    localparam int RSSX_ADDR_W = 4;

    // ************************************************************
    // Status flag bit positions
    // ************************************************************
    localparam int RSSX_FLG_C = 0;
    localparam int RSSX_FLG_AC = 1;
    localparam int RSSX_FLG_Z = 2;
    localparam int RSSX_FLG_OV = 3;
    localparam int RSSX_FLG_SC = 4;
    localparam int RSSX_FLG_CZ = 5;
    localparam int RSSX_FLG_W = 6;

    // ************************************************************
    // Status register bits and reset values
    // ************************************************************
    localparam int RSSX_STS_BUSY = 0;
    localparam int RSSX_STS_SKIP = 1;
    localparam logic [7:0] RSSX_RST_BYTE = 8'h00;
    localparam logic [5:0] RSSX_RST_FLAGS = 6'h00;

    // ************************************************************
    // Operation codes written to the control register
    // ************************************************************
    localparam logic [2:0] RSSX_OP_ROT = 3'h1;
    localparam logic [2:0] RSSX_OP_SUB_MEM = 3'h2;
    localparam logic [2:0] RSSX_OP_SUB_IMM = 3'h3;
    localparam logic [2:0] RSSX_OP_SUB_TO_MEM = 3'h4;
    localparam logic [2:0] RSSX_OP_DEC_SKIP = 3'h5;
    localparam logic [2:0] RSSX_OP_DEC_SKIP_ACC = 3'h6;

    typedef enum logic [1:0] {
        RSSX_IDLE,
        RSSX_EXEC,
        RSSX_DUMMY
    } rssx_fsm_type;

    typedef struct packed {
        rssx_fsm_type fsm;
        logic [7:0] acc;
        logic [7:0] mem;
        logic [7:0] imm;
        logic [5:0] flags;
        logic [2:0] op;
        logic last_skip;
        logic skip_next;
        logic dummy;
        logic mem_write;
        logic waitreq;
        logic busy;
        logic [31:0] rdata;
    } rssx_state_type;

endpackage : rssx_pkg

// ### logic/rssx_exec.sv
// Rotate, subtract-with-borrow and decrement-skip execution datapath with Avalon-MM slave
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps

// Functional notes
// - Rotate right through carry into accumulator
// - Rotate keeps memory; changes carry only
// - Accumulator minus memory minus inverted carry
// - Accumulator minus immediate minus inverted carry
// - Same difference stored back into memory
// - Carry cleared on negative, else set
// - Subtracts update all six arithmetic flags
// - Decrement memory, skip if zero, flags kept
// - Decrement into accumulator, skip if zero
// - Decrement-skips take two cycles only when they skip, dummy inserted
module rssx_exec
    import rssx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [RSSX_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [7:0] mem_data,
    output logic mem_write,
    output logic skip_next,
    output logic dummy_cycle,
    output logic busy
);

    // ************************************************************
    // State
    // ************************************************************
    rssx_state_type s;
    rssx_state_type next_s;

    logic [8:0] diff9;
    logic [4:0] nib5;
    logic [7:0] opnd;
    logic [7:0] res;
    logic [7:0] dec;
    logic not_c;

    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign mem_data = s.mem;
    assign mem_write = s.mem_write;
    assign skip_next = s.skip_next;
    assign dummy_cycle = s.dummy;
    assign busy = s.busy;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        not_c = ~s.flags[RSSX_FLG_C];
        opnd = (s.op == RSSX_OP_SUB_IMM) ? s.imm : s.mem;
        // Nine-bit difference: bit 8 is the borrow out
        diff9 = {1'b0, s.acc} - {1'b0, opnd} - {8'h00, not_c};
        nib5 = {1'b0, s.acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, not_c};
        res = diff9[7:0];
        dec = s.mem - 8'h01;
        next_s = s;
        next_s.mem_write = 1'b0;
        next_s.skip_next = 1'b0;
        next_s.dummy = 1'b0;

        // Avalon slave: one wait cycle, then the answer stands one cycle
        if ((avs_read || avs_write) && s.waitreq) begin
            next_s.waitreq = 1'b0;
            next_s.rdata = 32'h00000000;
            if (avs_write && (s.fsm == RSSX_IDLE)) begin
                // Writes while busy are dropped so the datapath owns its registers
                if (avs_address == RSSX_OFS_CTRL) begin
                    next_s.op = avs_writedata[2:0];
                    next_s.fsm = RSSX_EXEC;
                end else if (avs_address == RSSX_OFS_ACC) begin
                    next_s.acc = avs_writedata[7:0];
                end else if (avs_address == RSSX_OFS_FLAGS) begin
                    next_s.flags = avs_writedata[RSSX_FLG_W-1:0];
                end else if (avs_address == RSSX_OFS_MEM) begin
                    next_s.mem = avs_writedata[7:0];
                end else if (avs_address == RSSX_OFS_IMM) begin
                    next_s.imm = avs_writedata[7:0];
                end
            end else if (avs_read) begin
                if (avs_address == RSSX_OFS_CTRL) begin
                    next_s.rdata = {29'h0, s.op};
                end else if (avs_address == RSSX_OFS_ACC) begin
                    next_s.rdata = {24'h0, s.acc};
                end else if (avs_address == RSSX_OFS_FLAGS) begin
                    next_s.rdata = {26'h0, s.flags};
                end else if (avs_address == RSSX_OFS_MEM) begin
                    next_s.rdata = {24'h0, s.mem};
                end else if (avs_address == RSSX_OFS_IMM) begin
                    next_s.rdata = {24'h0, s.imm};
                end else if (avs_address == RSSX_OFS_STATUS) begin
                    next_s.rdata = {30'h0, s.last_skip, busy};
                end
            end
        end else begin
            next_s.waitreq = 1'b1;
        end

        case (s.fsm)
            RSSX_EXEC: begin
                next_s.fsm = RSSX_IDLE;
                next_s.last_skip = 1'b0;
                if (s.op == RSSX_OP_ROT) begin
                    next_s.acc = {s.flags[RSSX_FLG_C], s.mem[7:1]};
                    next_s.flags[RSSX_FLG_C] = s.mem[0];
                end else if ((s.op == RSSX_OP_SUB_MEM) || (s.op == RSSX_OP_SUB_IMM) ||
                             (s.op == RSSX_OP_SUB_TO_MEM)) begin
                    if (s.op == RSSX_OP_SUB_TO_MEM) begin
                        next_s.mem = res;
                        next_s.mem_write = 1'b1;
                    end else begin
                        next_s.acc = res;
                    end
                    next_s.flags[RSSX_FLG_C] = ~diff9[8];
                    next_s.flags[RSSX_FLG_AC] = ~nib5[4];
                    next_s.flags[RSSX_FLG_Z] = (res == 8'h00);
                    next_s.flags[RSSX_FLG_OV] = (s.acc[7] != opnd[7]) && (res[7] != s.acc[7]);
                    // Sign of the true result: wrapped sign corrected by overflow
                    next_s.flags[RSSX_FLG_SC] = res[7] ^
                        ((s.acc[7] != opnd[7]) && (res[7] != s.acc[7]));
                    // Chained zero stays set only while every byte of the chain is zero
                    next_s.flags[RSSX_FLG_CZ] = (res == 8'h00) && s.flags[RSSX_FLG_CZ];
                end else if (s.op == RSSX_OP_DEC_SKIP) begin
                    next_s.mem = dec;
                    next_s.mem_write = 1'b1;
                    next_s.last_skip = (dec == 8'h00);
                    if (dec == 8'h00) begin
                        next_s.skip_next = 1'b1;
                        next_s.dummy = 1'b1;
                        next_s.fsm = RSSX_DUMMY;
                    end
                end else if (s.op == RSSX_OP_DEC_SKIP_ACC) begin
                    next_s.acc = dec;
                    next_s.last_skip = (dec == 8'h00);
                    if (dec == 8'h00) begin
                        next_s.skip_next = 1'b1;
                        next_s.dummy = 1'b1;
                        next_s.fsm = RSSX_DUMMY;
                    end
                end
            end
            RSSX_DUMMY: begin
                // Dummy slot while the sequencer fetches past the skipped word
                next_s.fsm = RSSX_IDLE;
            end
            default: begin
            end
        endcase
        // Registered copy so the busy pin comes straight from a flip-flop
        next_s.busy = (next_s.fsm != RSSX_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '{fsm: RSSX_IDLE, acc: RSSX_RST_BYTE, mem: RSSX_RST_BYTE, imm: RSSX_RST_BYTE,
                   flags: RSSX_RST_FLAGS, op: 3'h0, last_skip: 1'b0, skip_next: 1'b0,
                   dummy: 1'b0, mem_write: 1'b0, waitreq: 1'b1, rdata: 32'h00000000,
                   busy: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic is_sub;
    assign is_sub = (s.fsm == RSSX_EXEC) && ((s.op == RSSX_OP_SUB_MEM) ||
                    (s.op == RSSX_OP_SUB_IMM) || (s.op == RSSX_OP_SUB_TO_MEM));
    logic no_borrow;
    assign no_borrow = ({1'b0, s.acc} >= ({1'b0, opnd} + {8'h00, not_c}));

    // ************************************************************
    // Independent reference terms
    // ************************************************************
    // Signed difference two bits wider than a byte, so it never wraps
    logic [9:0] sdiff;
    assign sdiff = {{2{s.acc[7]}}, s.acc} - {{2{opnd[7]}}, opnd} - {9'h000, not_c};
    logic ovf_true;
    assign ovf_true = (sdiff[9:7] != 3'h0) && (sdiff[9:7] != 3'h7);
    // Low nibble compared as a whole rather than through a carry chain
    logic nib_no_borrow;
    assign nib_no_borrow = ({1'b0, s.acc[3:0]} >= ({1'b0, opnd[3:0]} + {4'h0, not_c}));

    sequence s_skip_exec;
        (s.fsm == RSSX_EXEC) && ((s.op == RSSX_OP_DEC_SKIP) || (s.op == RSSX_OP_DEC_SKIP_ACC));
    endsequence
    sequence s_dummy_then_idle;
        (s.dummy && s.skip_next && (s.fsm == RSSX_DUMMY)) ##1 (!s.dummy && (s.fsm == RSSX_IDLE));
    endsequence

    property p_rot_acc;
        (s.fsm == RSSX_EXEC) && (s.op == RSSX_OP_ROT) |=>
            (s.acc == {$past(s.flags[RSSX_FLG_C]), $past(s.mem[7:1])}) &&
            (s.flags[RSSX_FLG_C] == $past(s.mem[0]));
    endproperty
    a_rot_acc: assert property (p_rot_acc) else $error("rotate result wrong");

    property p_rot_keep;
        (s.fsm == RSSX_EXEC) && (s.op == RSSX_OP_ROT) |=>
            $stable(s.mem) && !s.mem_write && (s.flags[5:1] == $past(s.flags[5:1]));
    endproperty
    a_rot_keep: assert property (p_rot_keep) else $error("rotate touched memory or flags");

    property p_sub_acc;
        (s.fsm == RSSX_EXEC) && (s.op == RSSX_OP_SUB_MEM) |=>
            s.acc == $past(s.acc) - $past(s.mem) - {7'h00, ~$past(s.flags[RSSX_FLG_C])};
    endproperty
    a_sub_acc: assert property (p_sub_acc) else $error("memory subtract wrong");

    property p_sub_imm;
        (s.fsm == RSSX_EXEC) && (s.op == RSSX_OP_SUB_IMM) |=>
            s.acc == $past(s.acc) - $past(s.imm) - {7'h00, ~$past(s.flags[RSSX_FLG_C])};
    endproperty
    a_sub_imm: assert property (p_sub_imm) else $error("immediate subtract wrong");

    property p_sub_mem;
        (s.fsm == RSSX_EXEC) && (s.op == RSSX_OP_SUB_TO_MEM) |=> s.mem_write && $stable(s.acc) &&
            (s.mem == $past(s.acc) - $past(s.mem) - {7'h00, ~$past(s.flags[RSSX_FLG_C])});
    endproperty
    a_sub_mem: assert property (p_sub_mem) else $error("subtract to memory wrong");

    property p_sub_carry;
        is_sub |=> s.flags[RSSX_FLG_C] == $past(no_borrow);
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

    property p_sub_zero;
        is_sub && (s.op != RSSX_OP_SUB_TO_MEM) |=> s.flags[RSSX_FLG_Z] == (s.acc == 8'h00);
    endproperty
    a_sub_zero: assert property (p_sub_zero) else $error("subtract zero flag wrong");

    property p_dec_mem;
        (s.fsm == RSSX_EXEC) && (s.op == RSSX_OP_DEC_SKIP) |=> (s.mem == $past(s.mem) - 8'h01)
            && $stable(s.flags) && (s.skip_next == (s.mem == 8'h00));
    endproperty
    a_dec_mem: assert property (p_dec_mem) else $error("decrement skip wrong");

    property p_dec_acc;
        (s.fsm == RSSX_EXEC) && (s.op == RSSX_OP_DEC_SKIP_ACC) |=> (s.acc == $past(s.mem) - 8'h01)
            && $stable(s.mem) && $stable(s.flags) && (s.skip_next == (s.acc == 8'h00));
    endproperty
    a_dec_acc: assert property (p_dec_acc) else $error("decrement to accumulator wrong");

    property p_two_cycle;
        s_skip_exec ##1 s.skip_next |-> s_dummy_then_idle;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("skip dummy cycle missing");

    property p_sub_keep;
        (s.fsm == RSSX_EXEC) && ((s.op == RSSX_OP_SUB_MEM) || (s.op == RSSX_OP_SUB_IMM)) |=>
            $stable(s.mem) && !s.mem_write;
    endproperty
    a_sub_keep: assert property (p_sub_keep) else $error("subtract wrote memory");

    property p_imm_keep;
        (s.fsm == RSSX_EXEC) |=> $stable(s.imm);
    endproperty
    a_imm_keep: assert property (p_imm_keep) else $error("immediate byte changed");

    property p_sub_aux;
        is_sub |=> s.flags[RSSX_FLG_AC] == $past(nib_no_borrow);
    endproperty
    a_sub_aux: assert property (p_sub_aux) else $error("subtract nibble borrow wrong");

    property p_sub_sign;
        is_sub |=> (s.flags[RSSX_FLG_OV] == $past(ovf_true)) &&
            (s.flags[RSSX_FLG_SC] == $past(sdiff[9]));
    endproperty
    a_sub_sign: assert property (p_sub_sign) else $error("subtract overflow or sign wrong");

    property p_sub_chain;
        is_sub |=> s.flags[RSSX_FLG_CZ] ==
            (s.flags[RSSX_FLG_Z] && $past(s.flags[RSSX_FLG_CZ]));
    endproperty
    a_sub_chain: assert property (p_sub_chain) else $error("chained zero wrong");

    property p_sub_mem_zero;
        (s.fsm == RSSX_EXEC) && (s.op == RSSX_OP_SUB_TO_MEM) |=>
            s.flags[RSSX_FLG_Z] == (s.mem == 8'h00);
    endproperty
    a_sub_mem_zero: assert property (p_sub_mem_zero) else $error("memory zero wrong");

    property p_skip_dummy;
        s.skip_next |-> s.dummy && (s.fsm == RSSX_DUMMY);
    endproperty
    a_skip_dummy: assert property (p_skip_dummy) else $error("skip without dummy slot");

    property p_noskip_one;
        s_skip_exec ##1 !s.skip_next |-> (s.fsm == RSSX_IDLE) && !s.dummy;
    endproperty
    a_noskip_one: assert property (p_noskip_one) else $error("plain decrement too long");

endmodule : rssx_exec

// ### tb/rssx_seq_model.sv
// Sequencer and data-memory stand-in that watches the datapath outputs
`timescale 1ns/1ps
module rssx_seq_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] mem_data,
    input wire logic mem_write,
    input wire logic skip_next,
    input wire logic dummy_cycle,
    input wire logic busy,
    output int skip_cnt,
    output int mem_wr_cnt,
    output int busy_len,
    output int pair_err,
    output logic [7:0] mem_img
);
    int run;
    // Pulses last one cycle, so they are counted here at every edge
    always @(posedge ref_clk) begin
        if (rst) begin
            skip_cnt <= 0;
            mem_wr_cnt <= 0;
            busy_len <= 0;
            pair_err <= 0;
            run <= 0;
            mem_img <= 8'h00;
        end else begin
            if (skip_next) skip_cnt <= skip_cnt + 1;
            if (mem_write) begin
                mem_wr_cnt <= mem_wr_cnt + 1;
                mem_img <= mem_data;
            end
            if (skip_next !== dummy_cycle) pair_err <= pair_err + 1;
            if (busy) begin
                run <= run + 1;
            end else if (run != 0) begin
                busy_len <= run;
                run <= 0;
            end
        end
    end
endmodule : rssx_seq_model

// ### tb/tb_top.sv
// Self-checking bench for the rotate, subtract and decrement-skip datapath
`timescale 1ns/1ps
module tb_top;
    import rssx_pkg::*;
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] mem;
        logic [5:0] flg;
        logic skip;
        logic memw;
    } rssx_exp_type;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [RSSX_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, mem_write, skip_next, dummy_cycle, busy;
    logic [7:0] mem_data, mem_img;
    logic [15:0] lfsr = 16'h0002;
    logic [15:0] r2;
    int skip_cnt, mem_wr_cnt, busy_len, pair_err, s0, w0;
    int mismatches = 0;
    int checked = 0;
    rssx_exp_type e;

    rssx_exec i_rssx_exec (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_data(mem_data),
        .mem_write(mem_write), .skip_next(skip_next), .dummy_cycle(dummy_cycle), .busy(busy));
    rssx_seq_model i_rssx_seq_model (.ref_clk(ref_clk), .rst(rst), .mem_data(mem_data),
        .mem_write(mem_write), .skip_next(skip_next), .dummy_cycle(dummy_cycle), .busy(busy),
        .skip_cnt(skip_cnt), .mem_wr_cnt(mem_wr_cnt), .busy_len(busy_len),
        .pair_err(pair_err), .mem_img(mem_img));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Reference arithmetic
    // ************************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic rssx_exp_type predict(input logic [2:0] op, input logic [7:0] a, m, i,
        input logic [5:0] f);
        rssx_exp_type r;
        logic [8:0] d;
        logic [4:0] n;
        logic [7:0] b;
        r = '{acc: a, mem: m, flg: f, skip: 1'b0, memw: 1'b0};
        b = (op == RSSX_OP_SUB_IMM) ? i : m;
        d = {1'b0, a} - {1'b0, b} - {8'h00, ~f[RSSX_FLG_C]};
        n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~f[RSSX_FLG_C]};
        case (op)
            RSSX_OP_ROT: begin
                r.acc = {f[RSSX_FLG_C], m[7:1]};
                r.flg[RSSX_FLG_C] = m[0];
            end
            RSSX_OP_SUB_MEM, RSSX_OP_SUB_IMM, RSSX_OP_SUB_TO_MEM: begin
                r.memw = (op == RSSX_OP_SUB_TO_MEM);
                if (r.memw) r.mem = d[7:0];
                else r.acc = d[7:0];
                r.flg[RSSX_FLG_C] = ~d[8];
                r.flg[RSSX_FLG_AC] = ~n[4];
                r.flg[RSSX_FLG_Z] = (d[7:0] == 8'h00);
                r.flg[RSSX_FLG_OV] = (a[7] ^ b[7]) & (a[7] ^ d[7]);
                r.flg[RSSX_FLG_SC] = r.flg[RSSX_FLG_OV] ^ d[7];
                r.flg[RSSX_FLG_CZ] = r.flg[RSSX_FLG_Z] & f[RSSX_FLG_CZ];
            end
            RSSX_OP_DEC_SKIP: begin
                r.mem = m - 8'h01;
                r.memw = 1'b1;
                r.skip = (r.mem == 8'h00);
            end
            RSSX_OP_DEC_SKIP_ACC: begin
                r.acc = m - 8'h01;
                r.skip = (r.acc == 8'h00);
            end
            default: ;
        endcase
        return r;
    endfunction : predict

    // ************************************************************
    // Bus, compare and sequence tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic run_op(input logic [2:0] op, input logic [7:0] a, m, i, input logic [5:0] f);
        e = predict(op, a, m, i, f);
        bus(1'b1, RSSX_OFS_ACC, {24'h0, a});
        bus(1'b1, RSSX_OFS_MEM, {24'h0, m});
        bus(1'b1, RSSX_OFS_IMM, {24'h0, i});
        bus(1'b1, RSSX_OFS_FLAGS, {26'h0, f});
        s0 = skip_cnt;
        w0 = mem_wr_cnt;
        bus(1'b1, RSSX_OFS_CTRL, {29'h0, op});
        // Completion is fixed at two cycles after the accept at the latest
        repeat (4) @(posedge ref_clk);
        bus(1'b0, RSSX_OFS_ACC, '0);
        check(rd, {24'h0, e.acc});
        bus(1'b0, RSSX_OFS_FLAGS, '0);
        check(rd, {26'h0, e.flg});
        bus(1'b0, RSSX_OFS_MEM, '0);
        check(rd, {24'h0, e.mem});
        bus(1'b0, RSSX_OFS_STATUS, '0);
        check(rd, {30'h0, e.skip, 1'b0});
        check(32'(skip_cnt - s0), {31'h0, e.skip});
        check(32'(mem_wr_cnt - w0), {31'h0, e.memw});
        if (e.memw) check({24'h0, mem_img}, {24'h0, e.mem});
        check(32'(busy_len), e.skip ? 32'h2 : 32'h1);
        check(32'(pair_err), 32'h0);
    endtask : run_op

    task automatic test_done();
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        bus(1'b0, RSSX_OFS_FLAGS, '0);
        check(rd, {26'h0, RSSX_RST_FLAGS});
        bus(1'b0, 4'hf, '0);
        check(rd, 32'h0);
        run_op(RSSX_OP_SUB_MEM, 8'h00, 8'h00, 8'h00, 6'h20);
        run_op(RSSX_OP_SUB_IMM, 8'h80, 8'h00, 8'h01, 6'h01);
        run_op(RSSX_OP_SUB_TO_MEM, 8'h10, 8'h01, 8'h00, 6'h01);
        run_op(RSSX_OP_SUB_MEM, 8'h05, 8'h05, 8'h00, 6'h21);
        run_op(RSSX_OP_DEC_SKIP, 8'h00, 8'h01, 8'h00, 6'h3f);
        run_op(RSSX_OP_DEC_SKIP, 8'h00, 8'h00, 8'h00, 6'h00);
        run_op(RSSX_OP_DEC_SKIP_ACC, 8'h77, 8'h01, 8'h00, 6'h00);
        run_op(RSSX_OP_ROT, 8'h55, 8'h01, 8'h00, 6'h3e);
        run_op(RSSX_OP_ROT, 8'h55, 8'hfe, 8'h00, 6'h01);
        // Unused op codes must run one idle exec cycle and change nothing
        run_op(3'h0, 8'h3c, 8'h5a, 8'ha5, 6'h15);
        run_op(3'h7, 8'hc3, 8'ha5, 8'h5a, 6'h2a);
        for (int k = 0; k < 60; k++) begin
            lfsr = lfsr_next(lfsr);
            r2 = lfsr;
            lfsr = lfsr_next(lfsr);
            run_op(3'(k % 6 + 1), r2[7:0], r2[15:8], lfsr[7:0], lfsr[13:8]);
        end
        bus(1'b1, RSSX_OFS_STATUS, 32'h3);
        bus(1'b0, RSSX_OFS_STATUS, '0);
        check(rd, {30'h0, e.skip, 1'b0});
        test_done();
    end

    initial begin
        repeat (10000) @(posedge ref_clk);
        mismatches++;
        test_done();
    end
endmodule : tb_top
